//--- fpa_cmd.sv
`timescale 1ns/10ps
`include "fpa_defines.svh"
// What this block does and what it expects of the host
// [R1] Password mode: unlock flag forced to 0 at power-up and hardware reset.
// [R2] Unlock flag set to 1 only by a full, matching password unlock.
// [R3] Password programming only clears bits; writing 1 over 0 is silent.
// [R4] 64-bit password, all ones initially, any value accepted.
// [R5] Password-mode lock bit at 0 blocks password programming; reads undefined.
// [R6] Protection-mode lock bits are one-time and cannot be erased.
// [R7] Wrong password sets program failure flag, keeps busy, flag stays 0.
// [R8] Unlock attempts accepted at most once per 100 us; busy meanwhile.
// [R9] Matching password clears busy at once, without the delay.
// [R10] Host polls busy via status 1 read before the next password command.
// [R11] Host programs region 3 read guard before or with password lock bit.
// [R12] Region 3 read guard acts only once password lock bit is 0.
// [R13] Read guard 0 blocks region 3 program/erase and invalidates its reads.
// [R14] Boot code issues lock-regions command when no changes are needed.
// [R15] Manufacturing order: regions, pointer region, password, then mode bits.
// [R16] Host drives select, clock, input; device drives output for single reads.
// [R17] Select low before first clock rise, low throughout, high ends command.
// [R18] Commands not ending on an 8-bit boundary are rejected.
// [R19] Dedicated opcodes always take a 32-bit address.
// [R20] Address-length bit 1 makes legacy commands take 4-byte addresses.
// [R21] Address-length bit loaded from nonvolatile copy on any reset.
// [R22] Legacy opcodes listed follow the address-length bit.
// [R23] Opcode A6 clears the unlock flag; only correct password sets it.
// [R24] Opcode EA is the password unlock, compared with stored password.
// [R25] Unlock flag 0 refuses changes to regions 2, 3 and pointer region.
// [R26] Software reset leaves the unlock flag unchanged.
// [R27] First eight bits after select falls are the opcode, MSB first.
// [R28] Password compared only after all 64 bits; early end fails.
module fpa_cmd
  import fpa_pkg::*;
#(
  parameter logic [15:0] UNLOCK_DELAY_CYC = 16'(`FPA_UNLOCK_DELAY_CYC)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sw_reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic password_mode,
  input wire logic pass_lock_n,
  input wire logic read_guard_cfg,
  input wire logic config2_nonvolatile,
  input wire logic addr_len_wr,
  input wire logic addr_len_val,
  output logic so,
  output logic so_oe,
  output logic region_unlock_flag,
  output logic region3_read_guard,
  output logic op_in_progress_flag,
  output logic program_fail_flag,
  output logic config2_volatile,
  output logic [7:0] opcode,
  output logic cmd_done,
  output logic cmd_reject,
  output logic [1:0] addr_bytes_code,
  output logic region_write_refused,
  output logic region3_read_invalid,
  output logic [63:0] password_q
);
  fpa_state_t state_q;
  logic cs_n_s, sck_s, si_s;
  logic sck_d1_q, cs_d1_q;
  logic [7:0] shift_q;
  logic [6:0] bit_cnt_q;
  logic [63:0] pass_shift_q;
  logic [7:0] op_q;
  logic [2:0] addr_left_q;
  logic timer_busy;
  logic timer_start;
  logic sck_rise, sck_fall, cs_rise, cs_fall;
  logic [7:0] byte_in;
  logic first_q;

  function automatic fpa_alen_t op_alen(input logic [7:0] op);
    case (op)
      `FPA_OP_READ4, `FPA_OP_FAST_READ4, `FPA_OP_DOR4, `FPA_OP_QOR4, `FPA_OP_DIOR4, `FPA_OP_QIOR4,
      `FPA_OP_DDRQIOR4, `FPA_OP_PP4, `FPA_OP_QPP4, `FPA_OP_SE4, `FPA_OP_HBE4, `FPA_OP_BE4,
      `FPA_OP_IBLRD4, `FPA_OP_IBLLOCK4, `FPA_OP_IBLUNLOCK4, `FPA_OP_SPRP4: op_alen = FPA_AL_FIXED32; // R19
      `FPA_OP_SFDP, `FPA_OP_READ, `FPA_OP_FAST_READ, `FPA_OP_DOR, `FPA_OP_QOR, `FPA_OP_DIOR,
      `FPA_OP_QIOR, `FPA_OP_DDRQIOR, `FPA_OP_PAGE_PROG, `FPA_OP_QPP, `FPA_OP_SECTOR_ERASE, `FPA_OP_HBE,
      `FPA_OP_BLOCK_ERASE, `FPA_OP_READ_ANY_REG, `FPA_OP_WRITE_ANY_REG, `FPA_OP_SECRE, `FPA_OP_SECRP,
      `FPA_OP_SECRR, `FPA_OP_IBLRD,
      `FPA_OP_IBLLOCK, `FPA_OP_IBLUNLOCK, `FPA_OP_SPRP: op_alen = FPA_AL_FOLLOW; // R22
      default: op_alen = FPA_AL_NONE;
    endcase
  endfunction

  function automatic logic is_region_change(input logic [7:0] op);
    is_region_change = (op == `FPA_OP_SECRE) || (op == `FPA_OP_SECRP) || (op == `FPA_OP_SPRP)
      || (op == `FPA_OP_SPRP4);
  endfunction

  fpa_sync #(.RESET_VAL(1'b1)) u_sync_cs (.clk(clk), .rst(rst), .ce(ce), .async_in(cs_n), .sync_out(cs_n_s));
  fpa_sync #(.RESET_VAL(1'b0)) u_sync_sck (.clk(clk), .rst(rst), .ce(ce), .async_in(sck), .sync_out(sck_s));
  fpa_sync #(.RESET_VAL(1'b0)) u_sync_si (.clk(clk), .rst(rst), .ce(ce), .async_in(si), .sync_out(si_s));

  fpa_unlock_timer #(.DELAY_CYC(UNLOCK_DELAY_CYC)) u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(timer_start),
    .busy(timer_busy)
  );

  // Edge detectors run on synchronised copies only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_d1_q <= 1'b0;
      cs_d1_q <= 1'b1;
    end else if (ce) begin
      sck_d1_q <= sck_s;
      cs_d1_q <= cs_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d1_q & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d1_q & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_d1_q;
  assign cs_fall = ~cs_n_s & cs_d1_q;
  assign byte_in = {shift_q[6:0], si_s};

  // Framing: opcode, address, data/password
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= FPA_ST_OPCODE;
      shift_q <= 8'h00;
      bit_cnt_q <= 7'h00;
      op_q <= 8'h00;
      addr_left_q <= 3'h0;
      pass_shift_q <= 64'h0000000000000000;
    end else if (ce) begin
      if (cs_fall || cs_n_s) begin
        state_q <= FPA_ST_OPCODE; // R17
        bit_cnt_q <= 7'h00;
        shift_q <= 8'h00;
      end else if (sck_rise) begin
        shift_q <= byte_in; // R27
        bit_cnt_q <= bit_cnt_q + 7'h01;
        if (bit_cnt_q[2:0] == 3'h7) begin
          case (state_q)
            FPA_ST_OPCODE: begin
              op_q <= byte_in; // R27
              if (byte_in == `FPA_OP_PASS_UNLOCK) begin
                state_q <= timer_busy ? FPA_ST_IGNORE : FPA_ST_PASS; // R8 R24
              end else if (op_alen(byte_in) == FPA_AL_FIXED32) begin
                state_q <= FPA_ST_ADDR;
                addr_left_q <= 3'h4; // R19
              end else if (op_alen(byte_in) == FPA_AL_FOLLOW) begin
                state_q <= FPA_ST_ADDR;
                addr_left_q <= config2_volatile ? 3'h4 : 3'h3; // R20
              end else begin
                state_q <= FPA_ST_DATA;
              end
            end
            FPA_ST_ADDR: begin
              addr_left_q <= addr_left_q - 3'h1;
              if (addr_left_q == 3'h1) begin
                state_q <= FPA_ST_DATA;
              end
            end
            FPA_ST_PASS: pass_shift_q <= {pass_shift_q[55:0], byte_in};
            FPA_ST_DATA: begin
              if (op_q == `FPA_OP_PASS_PROG && !pass_lock_n) begin
                state_q <= FPA_ST_IGNORE; // R5
              end
            end
            FPA_ST_IGNORE: state_q <= FPA_ST_IGNORE;
            default: state_q <= FPA_ST_IGNORE;
          endcase
        end else if (state_q == FPA_ST_PASS) begin
          pass_shift_q <= pass_shift_q;
        end
      end
    end
  end

  // Command completion and opcode report
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_done <= 1'b0;
      cmd_reject <= 1'b0;
      opcode <= 8'h00;
      addr_bytes_code <= 2'b00;
    end else if (ce) begin
      cmd_done <= cs_rise && (bit_cnt_q[2:0] == 3'h0) && (bit_cnt_q != 7'h00); // R18
      cmd_reject <= cs_rise && (bit_cnt_q[2:0] != 3'h0); // R18
      if (state_q == FPA_ST_OPCODE && sck_rise && bit_cnt_q[2:0] == 3'h7) begin
        opcode <= byte_in;
        addr_bytes_code <= op_alen(byte_in);
      end
    end
  end

  assign timer_start = cs_rise && state_q == FPA_ST_PASS && !timer_busy
    && !(bit_cnt_q == 7'h48 && pass_shift_q == password_q); // R28

  // Unlock flag and program failure flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      region_unlock_flag <= 1'b1;
      program_fail_flag <= 1'b0;
    end else if (ce) begin
      if (cs_rise && op_q == `FPA_OP_LOCK_REGIONS && bit_cnt_q == 7'h08) begin
        region_unlock_flag <= 1'b0; // R23 R14
      end else if (cs_rise && state_q == FPA_ST_PASS) begin
        if (bit_cnt_q == 7'h48 && pass_shift_q == password_q) begin
          region_unlock_flag <= 1'b1; // R2 R28
        end else begin
          program_fail_flag <= 1'b1; // R7 R28
        end
      end else if (!password_mode && first_q) begin
        region_unlock_flag <= 1'b1;
      end else if (password_mode && first_q) begin
        region_unlock_flag <= 1'b0; // R1
      end
      if (cs_rise && op_q == `FPA_OP_PASS_PROG && state_q == FPA_ST_DATA && !pass_lock_n) begin
        program_fail_flag <= program_fail_flag;
      end
    end
  end

  // First cycle after reset release loads the mode-dependent reset values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_q <= 1'b1;
    end else if (ce) begin
      first_q <= 1'b0;
    end
  end

  // Busy flag: held while the anti-guessing timer runs, and after a failure while a command is being ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_in_progress_flag <= 1'b0;
    end else if (ce) begin
      op_in_progress_flag <= timer_busy || timer_start || (program_fail_flag && state_q == FPA_ST_IGNORE); // R8 R9
    end
  end

  // Volatile configuration: address length and region 3 read guard
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config2_volatile <= 1'b0;
      region3_read_guard <= 1'b1;
    end else if (ce) begin
      if (first_q || sw_reset) begin
        config2_volatile <= config2_nonvolatile; // R21
        region3_read_guard <= (password_mode && !pass_lock_n) ? read_guard_cfg : 1'b1; // R12
      end else if (addr_len_wr) begin
        config2_volatile <= addr_len_val; // R20
      end else if (cs_rise && state_q == FPA_ST_PASS && bit_cnt_q == 7'h48 && pass_shift_q == password_q) begin
        region3_read_guard <= 1'b1;
      end
    end
  end

  // Password storage: program only clears bits, locked once mode bit is 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      password_q <= `FPA_PASSWORD_RESET; // R4
    end else if (ce) begin
      if (state_q == FPA_ST_DATA && op_q == `FPA_OP_PASS_PROG && pass_lock_n && sck_rise
          && bit_cnt_q[2:0] == 3'h7 && bit_cnt_q < 7'h48) begin
        password_q <= password_q & ~(64'h00000000000000FF << ((7'h47 - bit_cnt_q) & 7'h38)) |
          (password_q & ({56'h0, byte_in} << ((7'h47 - bit_cnt_q) & 7'h38))); // R3 R5
      end
    end
  end

  // Refusals and single-line read output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      region_write_refused <= 1'b0;
      region3_read_invalid <= 1'b0;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (ce) begin
      region_write_refused <= (state_q != FPA_ST_OPCODE) && !cs_n_s
        && ((is_region_change(op_q) && !region_unlock_flag) // R25
        || ((op_q == `FPA_OP_SECRE || op_q == `FPA_OP_SECRP) && !region3_read_guard)); // R13
      region3_read_invalid <= !cs_n_s && op_q == `FPA_OP_SECRR && !region3_read_guard; // R13
      so_oe <= !cs_n_s && state_q == FPA_ST_DATA && op_q == `FPA_OP_STATUS1_READ; // R16
      if (sck_fall) begin
        so <= op_in_progress_flag;
      end
    end
  end

  // R26: sw_reset does not touch region_unlock_flag
  // R6: protection-mode bits are inputs here, never cleared by this block
  // R10 R11 R15: host obligations

  AST_REJECT: assert property (@(posedge clk) disable iff (rst) // R18
    (ce && cs_rise && bit_cnt_q[2:0] != 3'h0) |=> cmd_reject)
    else $error("partial byte command not rejected");
  AST_LOCK: assert property (@(posedge clk) disable iff (rst) // R23
    (ce && cs_rise && op_q == `FPA_OP_LOCK_REGIONS && bit_cnt_q == 7'h08) |=> !region_unlock_flag)
    else $error("lock regions did not clear flag");
  AST_NOSET: assert property (@(posedge clk) disable iff (rst) // R2
    ($rose(region_unlock_flag) && !$past(first_q)) |-> $past(pass_shift_q == password_q))
    else $error("unlock flag set without password");
  AST_FAIL: assert property (@(posedge clk) disable iff (rst) // R7
    (ce && cs_rise && state_q == FPA_ST_PASS && bit_cnt_q != 7'h48) |=> program_fail_flag)
    else $error("short password not failed");
  AST_BUSY: assert property (@(posedge clk) disable iff (rst) // R8
    timer_start |=> ##1 op_in_progress_flag)
    else $error("busy not held after failed unlock");
  AST_ALEN: assert property (@(posedge clk) disable iff (rst) // R21
    (ce && sw_reset) |=> (config2_volatile == $past(config2_nonvolatile)))
    else $error("address length not reloaded");
  AST_PASS_CLR: assert property (@(posedge clk) disable iff (rst) // R3
    ce |=> ((password_q & ~$past(password_q)) == 64'h0))
    else $error("password bit went from 0 to 1");
  AST_ADDR4: assert property (@(posedge clk) disable iff (rst) // R20
    (ce && sck_rise && state_q == FPA_ST_OPCODE && bit_cnt_q[2:0] == 3'h7
      && op_alen(byte_in) == FPA_AL_FOLLOW && config2_volatile) |=> addr_left_q == 3'h4)
    else $error("legacy command not given 4 address bytes");
endmodule

//--- fpa_defines.svh
`ifndef FPA_DEFINES_SVH
`define FPA_DEFINES_SVH

`define FPA_OP_PASS_UNLOCK 8'hEA
`define FPA_OP_LOCK_REGIONS 8'hA6
`define FPA_OP_STATUS1_READ 8'h05
`define FPA_OP_READ_ANY_REG 8'h65
`define FPA_OP_WRITE_ANY_REG 8'h71
`define FPA_OP_READ 8'h03
`define FPA_OP_FAST_READ 8'h0B
`define FPA_OP_DOR 8'h3B
`define FPA_OP_QOR 8'h6B
`define FPA_OP_DIOR 8'hBB
`define FPA_OP_QIOR 8'hEB
`define FPA_OP_DDRQIOR 8'hED
`define FPA_OP_PAGE_PROG 8'h02
`define FPA_OP_QPP 8'h32
`define FPA_OP_SECTOR_ERASE 8'h20
`define FPA_OP_HBE 8'h52
`define FPA_OP_BLOCK_ERASE 8'hD8
`define FPA_OP_SFDP 8'h5A
`define FPA_OP_SECRE 8'h44
`define FPA_OP_SECRP 8'h42
`define FPA_OP_SECRR 8'h48
`define FPA_OP_IBLRD 8'h3D
`define FPA_OP_IBLLOCK 8'h36
`define FPA_OP_IBLUNLOCK 8'h39
`define FPA_OP_SPRP 8'hFB
`define FPA_OP_PASS_PROG 8'hE8
`define FPA_OP_PASS_READ 8'hE7
`define FPA_OP_READ4 8'h13
`define FPA_OP_FAST_READ4 8'h0C
`define FPA_OP_DOR4 8'h3C
`define FPA_OP_QOR4 8'h6C
`define FPA_OP_DIOR4 8'hBC
`define FPA_OP_QIOR4 8'hEC
`define FPA_OP_DDRQIOR4 8'hEE
`define FPA_OP_PP4 8'h12
`define FPA_OP_QPP4 8'h34
`define FPA_OP_SE4 8'h21
`define FPA_OP_HBE4 8'h53
`define FPA_OP_BE4 8'hDC
`define FPA_OP_IBLRD4 8'hE0
`define FPA_OP_IBLLOCK4 8'hE1
`define FPA_OP_IBLUNLOCK4 8'hE2
`define FPA_OP_SPRP4 8'hE3

`define FPA_PASSWORD_RESET 64'hFFFFFFFFFFFFFFFF
`define FPA_CLK_MHZ 200
`define FPA_UNLOCK_DELAY_US 100
`define FPA_UNLOCK_DELAY_CYC (`FPA_UNLOCK_DELAY_US * `FPA_CLK_MHZ)

`endif

//--- fpa_pkg.sv
package fpa_pkg;
  typedef enum logic [2:0] {
    FPA_ST_OPCODE = 3'b000,
    FPA_ST_ADDR = 3'b001,
    FPA_ST_DATA = 3'b010,
    FPA_ST_PASS = 3'b011,
    FPA_ST_IGNORE = 3'b100
  } fpa_state_t;

  typedef enum logic [1:0] {
    FPA_AL_NONE = 2'b00,
    FPA_AL_FOLLOW = 2'b01,
    FPA_AL_FIXED32 = 2'b10
  } fpa_alen_t;
endpackage

//--- fpa_sync.sv
`timescale 1ns/10ps
module fpa_sync
  import fpa_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // Reset to the pin's idle level so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- fpa_unlock_timer.sv
`timescale 1ns/10ps
`include "fpa_defines.svh"
module fpa_unlock_timer
  import fpa_pkg::*;
#(
  parameter logic [15:0] DELAY_CYC = 16'(`FPA_UNLOCK_DELAY_CYC)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  output logic busy
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (ce) begin
      if (start) begin
        cnt_q <= DELAY_CYC;
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  assign busy = (cnt_q != 16'h0000);
endmodule

//--- fpa_host.sv
`timescale 1ns/10ps
module fpa_host
  import fpa_pkg::*;
(
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic [7:0] status_q;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    status_q = 8'h00;
  end

  // Half of the 160 ns link period at the 5 ns system clock
  task automatic half_period;
    repeat (16) @(posedge clk);
    #1;
  endtask

  // Opcode then n data bits, MSB first; sck rests low between frames
  task automatic frame(input logic [7:0] op, input logic [63:0] dat, input int n);
    logic [71:0] sh;
    sh = {op, dat};
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      si = sh[71-i];
      half_period();
      sck = 1'b1;
      if (i >= 8) begin
        status_q = {status_q[6:0], so};
      end
      half_period();
      sck = 1'b0;
    end
    half_period();
    cs_n = 1'b1;
    // Released line must not keep showing the last bit
    si = ~si;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Status 1 read; bit 0 of the returned byte is the busy flag
  task automatic poll_status(output logic [7:0] st);
    frame(8'h05, 64'h0, 8);
    st = status_q;
  endtask
endmodule

//--- tb.sv
`timescale 1ns/10ps
module tb
  import fpa_pkg::*;
();
  logic clk, rst, ce, sw_reset, password_mode, pass_lock_n, read_guard_cfg;
  logic config2_nonvolatile, addr_len_wr, addr_len_val;
  logic cs_n, sck, si, so, so_oe, region_unlock_flag, region3_read_guard;
  logic op_in_progress_flag, program_fail_flag, config2_volatile, cmd_done, cmd_reject;
  logic region_write_refused, region3_read_invalid;
  logic [7:0] opcode;
  logic [7:0] st;
  logic [1:0] addr_bytes_code;
  logic [63:0] password_q;
  logic [63:0] exp_pw;
  logic saw_rej, saw_ref, saw_inv;
  int n_fail, checks, cyc, waited;
  logic [7:0] ops [18] = '{8'h13, 8'h12, 8'h21, 8'h0C, 8'hDC, 8'hE3, 8'h03, 8'h0B, 8'h02,
                          8'h20, 8'hD8, 8'h65, 8'h71, 8'h44, 8'h42, 8'h48, 8'hFB, 8'h05};

  fpa_cmd #(.UNLOCK_DELAY_CYC(16'hFA0)) dut (.clk(clk), .rst(rst), .ce(ce), .sw_reset(sw_reset),
    .cs_n(cs_n), .sck(sck), .si(si), .password_mode(password_mode), .pass_lock_n(pass_lock_n),
    .read_guard_cfg(read_guard_cfg), .config2_nonvolatile(config2_nonvolatile),
    .addr_len_wr(addr_len_wr), .addr_len_val(addr_len_val), .so(so), .so_oe(so_oe),
    .region_unlock_flag(region_unlock_flag), .region3_read_guard(region3_read_guard),
    .op_in_progress_flag(op_in_progress_flag), .program_fail_flag(program_fail_flag),
    .config2_volatile(config2_volatile), .opcode(opcode), .cmd_done(cmd_done),
    .cmd_reject(cmd_reject), .addr_bytes_code(addr_bytes_code),
    .region_write_refused(region_write_refused), .region3_read_invalid(region3_read_invalid),
    .password_q(password_q));

  fpa_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (cmd_reject === 1'b1) begin
      saw_rej <= 1'b1;
    end
    if (region_write_refused === 1'b1) begin
      saw_ref <= 1'b1;
    end
    if (region3_read_invalid === 1'b1) begin
      saw_inv <= 1'b1;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic pulse_in(input int which);
    @(posedge clk);
    #1;
    if (which == 0) sw_reset = 1'b1;
    else addr_len_wr = 1'b1;
    @(posedge clk);
    #1;
    sw_reset = 1'b0;
    addr_len_wr = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic wait_idle;
    waited = 0;
    while (op_in_progress_flag !== 1'b0 && waited < 6000) begin
      @(posedge clk);
      waited++;
    end
    #1;
    chk("busy_timeout", 1'b0, op_in_progress_flag);
  endtask

  initial begin
    {ce, rst, password_mode, pass_lock_n, read_guard_cfg, config2_nonvolatile} = 6'b111111;
    {sw_reset, addr_len_wr, addr_len_val, saw_rej, saw_ref, saw_inv} = 6'h00;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    exp_pw = 64'hFFFFFFFFFFFFFFFF;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("unlock_after_reset", 1'b0, region_unlock_flag);
    chk("addr_len_reset", 1'b1, config2_volatile);
    chk("password_init", exp_pw, password_q);
    chk("guard_inactive", 1'b1, region3_read_guard);
    host.frame(8'hFB, 64'h0, 0);
    chk("refused_locked", 1'b1, saw_ref);
    host.frame(8'hE8, 64'h0123456789ABCDEF, 64);
    exp_pw = exp_pw & 64'h0123456789ABCDEF;
    chk("password_prog", exp_pw, password_q);
    host.frame(8'hE8, 64'hFFFF0000FFFF0000, 64);
    exp_pw = exp_pw & 64'hFFFF0000FFFF0000;
    chk("password_zero_only", exp_pw, password_q);
    chk("no_prog_error", 1'b0, program_fail_flag);
    pass_lock_n = 1'b0;
    read_guard_cfg = 1'b0;
    pulse_in(0);
    chk("guard_active", 1'b0, region3_read_guard);
    host.frame(8'h48, 64'h0, 0);
    chk("region3_invalid", 1'b1, saw_inv);
    host.frame(8'hE8, 64'h0, 64);
    chk("password_locked", exp_pw, password_q);
    addr_len_val = 1'b0;
    pulse_in(1);
    chk("addr_len_write", 1'b0, config2_volatile);
    foreach (ops[i]) begin
      host.frame(ops[i], 64'h0, 0);
      chk("opcode", ops[i], opcode);
      chk("addr_code", (i < 6) ? FPA_AL_FIXED32 : ((i < 17) ? FPA_AL_FOLLOW : FPA_AL_NONE), addr_bytes_code);
    end
    host.frame(8'hEA, ~exp_pw, 64);
    chk("wrong_fail", 1'b1, program_fail_flag);
    chk("wrong_busy", 1'b1, op_in_progress_flag);
    host.frame(8'hEA, exp_pw, 64);
    chk("retry_ignored", 1'b0, region_unlock_flag);
    chk("retry_busy", 1'b1, op_in_progress_flag);
    wait_idle();
    chk("delay_long", 1'b1, waited > 1000);
    host.frame(8'hEA, exp_pw, 64);
    chk("unlock_set", 1'b1, region_unlock_flag);
    chk("match_no_delay", 1'b0, op_in_progress_flag);
    saw_ref = 1'b0;
    host.frame(8'hFB, 64'h0, 0);
    chk("refused_unlocked", 1'b0, saw_ref);
    pulse_in(0);
    chk("swreset_keeps", 1'b1, region_unlock_flag);
    chk("swreset_addr_len", 1'b1, config2_volatile);
    host.frame(8'hA6, 64'h0, 0);
    chk("lock_regions", 1'b0, region_unlock_flag);
    host.frame(8'hFB, 64'h0, 0);
    chk("refused_relocked", 1'b1, saw_ref);
    host.frame(8'hEA, exp_pw, 56);
    chk("short_fail", 1'b1, program_fail_flag);
    chk("short_locked", 1'b0, region_unlock_flag);
    wait_idle();
    saw_rej = 1'b0;
    host.frame(8'h05, 64'h0, 4);
    chk("reject_partial", 1'b1, saw_rej);
    saw_rej = 1'b0;
    host.poll_status(st);
    chk("reject_whole", 1'b0, saw_rej);
    chk("status_busy_bit", 1'b0, st[0]);
    chk("so_released", 1'b0, so_oe);
    results();
  end
endmodule
